// ==== rtl/nvc_pkg.sv ====
package nvc_pkg;
    // ************************************************************
    // register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] ADDR_LOW   = 8'h00; // nv_address_low
    localparam logic [7:0] ADDR_HIGH  = 8'h04; // nv_address_high
    localparam logic [7:0] DATA_LOW   = 8'h08; // nv_data_low
    localparam logic [7:0] DATA_HIGH  = 8'h0C; // nv_data_high
    localparam logic [7:0] CONTROL    = 8'h10; // nv_control
    localparam logic [7:0] UNLOCK_KEY = 8'h14; // nv_unlock_key
    localparam logic [7:0] STATUS     = 8'h18; // write_complete_flag

    // ************************************************************
    // control field positions
    // ************************************************************
    localparam int CTL_RD    = 0;
    localparam int CTL_WR    = 1;
    localparam int CTL_WRITE_ENABLE_BIT  = 2;
    localparam int CTL_ERASE = 4;
    localparam int CTL_PMS   = 7;

    // ************************************************************
    // unlock keys and sizes
    // ************************************************************
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam int         EE_DEPTH   = 128;
    localparam int         PM_DEPTH   = 1024;
    localparam int         PM_ABITS   = 10;
    localparam int         BLK_WORDS  = 32;
    localparam int         BLK_LSB    = 5;
    localparam logic [13:0] ERASED_WORD = 14'h3FFF;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ         = 250;
    localparam int ERASE_US        = 2000;
    localparam int ERASE_CYCLES    = ERASE_US * CLK_MHZ;
    localparam int EE_WRITE_CYCLES = 16;
    localparam int SETUP_CYCLES    = 2;
    localparam int CNT_W           = 20;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        NVC_IDLE  = 3'b000,
        NVC_FWAIT = 3'b001,
        NVC_FREAD = 3'b010,
        NVC_EEWR  = 3'b011,
        NVC_SETUP = 3'b100,
        NVC_ERASE = 3'b101
    } nvc_state_t;

    typedef struct packed {
        logic       pms;
        logic       erase;
        logic       write_enable_bit;
        logic       wr;
        logic       rd;
    } nvc_ctl_t;
endpackage

// ==== rtl/nvc_top.sv ====
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] data read lands in data low next cycle
// [R2] data low holds until read or write
// [R3] write needs 55h then AAh then wr
// [R4] wr refused unless write enable set
// [R5] clearing write enable keeps write running
// [R6] hardware never clears write enable
// [R7] write end clears wr, sets complete flag
// [R8] software clears complete flag itself
// [R9] software checks wr before new write
// [R10] software loads address, data, clears select
// [R11] software keeps address within memory size
// [R12] software masks interrupts during unlock
// [R13] flash read takes second following cycle
// [R14] flash word shown in both data registers
// [R15] erase clears one 32-word block
// [R16] block picked by upper address bits
// [R17] erase needs select, enable, erase, key
// [R18] two setup cycles after wr for erase
// [R19] erase stalls core about 2 ms
// [R20] resume after stall, third instruction
// [R21] data write lasts configurable cycle count
module nvc_top
    import nvc_pkg::*;
#(
    parameter int ERASE_LEN = ERASE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             cpu_stall,
    output logic             cpu_skip
);
    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta;
    logic rst_sync_n;

    // async assert, two-flop release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ************************************************************
    // storage and state
    // ************************************************************
    logic [7:0]  ee_mem [EE_DEPTH];  // data eeprom array
    logic [13:0] pm_mem [PM_DEPTH];  // program flash array
    logic [7:0]  nv_address_low;
    logic [4:0]  nv_address_high;
    logic [7:0]  nv_data_low;
    logic [5:0]  nv_data_high;
    nvc_ctl_t    ctl;                // control bits
    logic        write_complete_flag;
    logic [1:0]  key_stage;          // 0 none, 1 saw 55h, 2 saw AAh
    nvc_state_t  state;
    logic [CNT_W-1:0] cnt;           // wait counter

    // ************************************************************
    // bus decode
    // ************************************************************
    wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr_acc   = req & wb_we_i & wb_sel_i[0];
    wire        rd_acc   = req & ~wb_we_i;
    wire [7:0]  wbyte    = wb_dat_i[7:0];
    wire        w_alow   = wr_acc & (wb_adr_i == ADDR_LOW);
    wire        w_ahigh  = wr_acc & (wb_adr_i == ADDR_HIGH);
    wire        w_dlow   = wr_acc & (wb_adr_i == DATA_LOW);
    wire        w_dhigh  = wr_acc & (wb_adr_i == DATA_HIGH);
    wire        w_ctl    = wr_acc & (wb_adr_i == CONTROL);
    wire        w_key    = wr_acc & (wb_adr_i == UNLOCK_KEY);
    wire        w_stat   = wr_acc & (wb_adr_i == STATUS);
    wire        idle     = (state == NVC_IDLE);
    wire [PM_ABITS-1:0] pm_addr =
        PM_ABITS'({nv_address_high, nv_address_low});
    wire [6:0]  ee_addr  = nv_address_low[6:0];
    // wr may only rise with key complete and enable set
    wire        wr_go    = w_ctl & wbyte[CTL_WR] & idle
                           & (key_stage == 2'd2)              // [R3]
                           & ctl.write_enable_bit;                        // [R4]
    wire        rd_go    = w_ctl & wbyte[CTL_RD] & idle & ~wr_go;
    wire        erase_go = wr_go & wbyte[CTL_PMS]
                           & wbyte[CTL_ERASE];                // [R17]
    wire        eew_go   = wr_go & ~wbyte[CTL_PMS];
    wire        ee_done  = (state == NVC_EEWR) & (cnt == '0);
    wire        er_done  = (state == NVC_ERASE) & (cnt == '0);

    // ************************************************************
    // read mux
    // ************************************************************
    logic [7:0] rdata;
    always_comb begin
        case (wb_adr_i)
            ADDR_LOW:   rdata = nv_address_low;
            ADDR_HIGH:  rdata = {3'h0, nv_address_high};
            DATA_LOW:   rdata = nv_data_low;
            DATA_HIGH:  rdata = {2'h0, nv_data_high};
            CONTROL:    rdata = {ctl.pms, 2'h0, ctl.erase, 1'b0,
                                 ctl.write_enable_bit, ctl.wr, ctl.rd};
            STATUS:     rdata = {7'h00, write_complete_flag};
            default:    rdata = 8'h00; // key and unmapped read zero
        endcase
    end

    // single-wait slave: ack one cycle after request
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= rd_acc ? {24'h000000, rdata} : 32'h0000_0000;
        end
    end

    // ************************************************************
    // unlock key tracker
    // ************************************************************
    // any other bus write with byte lane 0 enabled breaks the sequence
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            key_stage <= 2'd0;
        end else if (w_key && wbyte == KEY_FIRST) begin
            key_stage <= 2'd1;                                // [R3]
        end else if (w_key && wbyte == KEY_SECOND
                     && key_stage == 2'd1) begin
            key_stage <= 2'd2;                                // [R3]
        end else if (wr_acc) begin
            key_stage <= 2'd0;                                // [R3]
        end
    end

    // ************************************************************
    // control and sequencer
    // ************************************************************
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= NVC_IDLE;
            cnt   <= '0;
            ctl   <= '0;
        end else begin
            if (w_ctl) begin
                ctl.write_enable_bit <= wbyte[CTL_WRITE_ENABLE_BIT];   // only software [R6]
                if (idle) begin
                    ctl.pms   <= wbyte[CTL_PMS];
                    ctl.erase <= wbyte[CTL_ERASE];
                end
            end
            case (state)
                NVC_IDLE: begin
                    if (eew_go) begin
                        state  <= NVC_EEWR;
                        cnt    <= CNT_W'(EE_WRITE_CYCLES - 1); // [R21]
                        ctl.wr <= 1'b1;
                    end else if (erase_go) begin
                        state  <= NVC_SETUP;
                        cnt    <= CNT_W'(SETUP_CYCLES - 1);    // [R18]
                        ctl.wr <= 1'b1;
                    end else if (rd_go && wbyte[CTL_PMS]) begin
                        state  <= NVC_FWAIT;                   // [R13]
                        ctl.rd <= 1'b1;
                    end
                end
                NVC_FWAIT: state <= NVC_FREAD;                 // [R13]
                NVC_FREAD: begin
                    state  <= NVC_IDLE;
                    ctl.rd <= 1'b0;
                end
                NVC_EEWR: begin
                    // write_enable_bit is not looked at here [R5]
                    if (ee_done) begin
                        state  <= NVC_IDLE;
                        ctl.wr <= 1'b0;                        // [R7]
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                NVC_SETUP: begin
                    if (cnt == '0) begin
                        state <= NVC_ERASE;
                        cnt   <= CNT_W'(ERASE_LEN - 1);        // [R19]
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                NVC_ERASE: begin
                    if (er_done) begin
                        state  <= NVC_IDLE;                    // [R20]
                        ctl.wr <= 1'b0;                        // [R7]
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: state <= NVC_IDLE;
            endcase
        end
    end

    // core halts during the erase only; setup lets the nops run
    assign cpu_stall = (state == NVC_ERASE);                   // [R19]
    // the instruction in the flash read cycle is discarded
    assign cpu_skip  = (state == NVC_FREAD);                   // [R13]

    // ************************************************************
    // address, data and completion flag
    // ************************************************************
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            nv_address_low      <= 8'h00;
            nv_address_high     <= 5'h00;
            nv_data_low         <= 8'h00;
            nv_data_high        <= 6'h00;
            write_complete_flag <= 1'b0;
        end else begin
            if (w_alow)  nv_address_low  <= wbyte;
            if (w_ahigh) nv_address_high <= wbyte[4:0];
            if (w_dlow && idle) begin
                nv_data_low <= wbyte;                          // [R2]
            end else if (rd_go && !wbyte[CTL_PMS]) begin
                nv_data_low <= ee_mem[ee_addr];                // [R1]
            end else if (state == NVC_FREAD) begin
                nv_data_low <= pm_mem[pm_addr][7:0];           // [R14]
            end
            if (w_dhigh && idle) begin
                nv_data_high <= wbyte[5:0];
            end else if (state == NVC_FREAD) begin
                nv_data_high <= pm_mem[pm_addr][13:8];         // [R14]
            end
            // set wins over a clear in the same cycle
            if (ee_done || er_done) begin
                write_complete_flag <= 1'b1;                   // [R7]
            end else if (w_stat && !wbyte[0]) begin
                write_complete_flag <= 1'b0;
            end
        end
    end

    // ************************************************************
    // arrays: no reset, contents are nonvolatile
    // ************************************************************
    always_ff @(posedge clk) begin
        if (ee_done) begin
            ee_mem[ee_addr] <= nv_data_low;
        end
    end

    // whole block wiped at erase end; low five bits ignored
    // one process per word, so no two processes share an element
    for (genvar i = 0; i < PM_DEPTH; i++) begin : g_word
        // word belongs to the picked block of 32
        wire hit = (pm_addr[PM_ABITS-1:BLK_LSB]
                    == (PM_ABITS-BLK_LSB)'(i / BLK_WORDS));   // [R16]
        always_ff @(posedge clk) begin
            if (er_done && hit) begin
                pm_mem[i] <= ERASED_WORD;                     // [R15]
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    // cycles spent in the data write; a counter keeps the check cheap
    logic [7:0] ee_len;
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ee_len <= 8'h00;
        end else if (eew_go) begin
            ee_len <= 8'h00;
        end else if (state == NVC_EEWR) begin
            ee_len <= ee_len + 8'h01;
        end
    end

    chk_wr_needs_write_enable_bit: assert property ( // [R4]
        @(posedge clk) disable iff (!rst_sync_n)
        $rose(ctl.wr) |-> $past(ctl.write_enable_bit))
        else $error("wr set without write enable");
    chk_wr_needs_key: assert property ( // [R3]
        @(posedge clk) disable iff (!rst_sync_n)
        $rose(ctl.wr) |-> $past(key_stage) == 2'd2)
        else $error("wr set without unlock key");
    chk_ee_duration: assert property ( // [R21]
        @(posedge clk) disable iff (!rst_sync_n)
        ee_done |=> !ctl.wr && ee_len == 8'(EE_WRITE_CYCLES))
        else $error("data write length wrong");
    chk_ee_wr_held: assert property ( // [R21]
        @(posedge clk) disable iff (!rst_sync_n)
        (state == NVC_EEWR) |-> ctl.wr)
        else $error("write bit dropped during data write");
    chk_done_flag: assert property ( // [R7]
        @(posedge clk) disable iff (!rst_sync_n)
        $fell(ctl.wr) |-> write_complete_flag)
        else $error("completion flag not set");
    chk_flash_skip: assert property ( // [R13]
        @(posedge clk) disable iff (!rst_sync_n)
        (rd_go && wbyte[CTL_PMS]) |=> !cpu_skip ##1 cpu_skip)
        else $error("flash read cycle misplaced");
    chk_erase_setup: assert property ( // [R18]
        @(posedge clk) disable iff (!rst_sync_n)
        erase_go |=> !cpu_stall [*2] ##1 cpu_stall)
        else $error("erase setup not two cycles");
    chk_write_enable_bit_kept: assert property ( // [R6]
        @(posedge clk) disable iff (!rst_sync_n)
        $fell(ctl.write_enable_bit) |-> $past(w_ctl))
        else $error("write enable cleared by hardware");
    chk_ee_read: assert property ( // [R1]
        @(posedge clk) disable iff (!rst_sync_n)
        (rd_go && !wbyte[CTL_PMS])
        |=> nv_data_low == ee_mem[$past(ee_addr)])
        else $error("eeprom read data wrong");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********************************************************
// bench for the nonvolatile access controller
// ********************************************************
module tb;
    import nvc_pkg::*;
    localparam int ELEN = 20;     // short erase so the run stays small
    logic        clk;             // 250 MHz system clock
    logic        rst_n;           // active low reset
    logic        cyc;             // bus cycle
    logic        stb;             // bus strobe
    logic        we;              // bus write
    logic [7:0]  adr;             // bus byte address
    logic [3:0]  sel;             // byte enables
    logic [31:0] dat;             // write data
    logic [31:0] dat_o;           // read data
    logic        ack;             // bus answer
    logic        stall;           // core halted
    logic        skip;            // instruction ignored
    int          fails;           // mismatches
    int          tests_run;       // comparisons
    int          seed;            // random seed
    int          stall_cnt;       // stalled cycles seen
    int          skip_cnt;        // skipped cycles seen
    int          ee_model[int];   // expected data bytes by address
    logic [31:0] q;               // scratch read value
    logic [7:0]  a;               // scratch address
    logic [7:0]  d;               // scratch data
    nvc_top #(.ERASE_LEN(ELEN)) nvc_top_inst (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .cpu_stall(stall),
        .cpu_skip(skip)
    );
    // ********************************************************
    // clock and core-side monitors
    // ********************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // count stall and skip cycles; both must be exact, not just seen
    always @(posedge clk) begin
        if (stall === 1'b1) stall_cnt++;
        if (skip === 1'b1) skip_cnt++;
    end
    // ********************************************************
    // bus and compare tasks
    // ********************************************************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one classic cycle; held until ack is sampled, then released;
    // no cycle count is assumed, the watchdog ends a hung wait
    task automatic wb(input logic w, input logic [7:0] ad,
                      input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= ad;
        dat <= wd;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    // key pair then the control byte; any write between with lane 0 on would break it
    task automatic unlock_go(input logic [7:0] ctl);
        logic [31:0] r;
        wb(1'b1, UNLOCK_KEY, {24'h0, KEY_FIRST}, r);
        wb(1'b1, UNLOCK_KEY, {24'h0, KEY_SECOND}, r);
        wb(1'b1, CONTROL, {24'h0, ctl}, r);
    endtask
    // poll the write bit with a bound instead of a fixed wait
    task automatic wait_done;
        logic [31:0] r;
        int n;
        n = 0;
        do begin
            wb(1'b0, CONTROL, 32'h0, r);
            n++;
        end while (r[CTL_WR] !== 1'b0 && n < 100);
        chk("write bit end", 32'h0, {31'h0, r[CTL_WR]});
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ********************************************************
    // watchdog: the whole run needs a few hundred cycles
    // ********************************************************
    initial begin
        #200000;
        fails++;
        close_out();
    end
    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        seed = 52;
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        dat = 32'h0;
        stall_cnt = 0;
        skip_cnt = 0;
        fails = 0;
        tests_run = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        wb(1'b0, CONTROL, 32'h0, q);
        chk("control reset", 32'h0, q);
        wb(1'b0, STATUS, 32'h0, q);
        chk("status reset", 32'h0, q);
        $display("test reset done");
        // refused starts: no enable, then a key pair split by another write
        wb(1'b1, ADDR_LOW, 32'h10, q);
        wb(1'b1, DATA_LOW, 32'h5A, q);
        // a write with its byte lane off must leave the register alone
        sel <= 4'h0;
        wb(1'b1, DATA_LOW, 32'hC3, q);
        sel <= 4'hF;
        wb(1'b0, DATA_LOW, 32'h0, q);
        chk("lane masked", 32'h5A, q);
        unlock_go(8'h02);
        wb(1'b0, CONTROL, 32'h0, q);
        chk("wr without enable", 32'h0, q);
        wb(1'b1, CONTROL, 32'h04, q);
        wb(1'b1, UNLOCK_KEY, {24'h0, KEY_FIRST}, q);
        wb(1'b1, ADDR_LOW, 32'h10, q);
        wb(1'b1, UNLOCK_KEY, {24'h0, KEY_SECOND}, q);
        wb(1'b1, CONTROL, 32'h06, q);
        wb(1'b0, CONTROL, 32'h0, q);
        chk("wr broken key", 32'h04, q);
        wb(1'b0, STATUS, 32'h0, q);
        chk("flag after refusal", 32'h0, q);
        $display("test refuse done");
        // random byte writes; the second drops enable mid-write
        for (int i = 0; i < 4; i++) begin
            a = 8'($random(seed)) & 8'h7F;
            d = 8'($random(seed));
            wb(1'b1, ADDR_LOW, {24'h0, a}, q);
            wb(1'b1, DATA_LOW, {24'h0, d}, q);
            wb(1'b1, CONTROL, 32'h04, q);
            unlock_go(8'h06);
            wb(1'b0, CONTROL, 32'h0, q);
            chk("wr running", 32'h06, q);
            if (i == 1) wb(1'b1, CONTROL, 32'h00, q);
            wait_done();
            wb(1'b0, STATUS, 32'h0, q);
            chk("complete flag", 32'h1, q);
            wb(1'b0, CONTROL, 32'h0, q);
            chk("enable kept", (i == 1) ? 32'h0 : 32'h04, q);
            wb(1'b1, STATUS, 32'h0, q);
            ee_model[int'(a)] = int'(d);
        end
        $display("test write done");
        // read back every written byte, twice to see it held
        foreach (ee_model[k]) begin
            wb(1'b1, ADDR_LOW, 32'(k), q);
            wb(1'b1, CONTROL, 32'h01, q);
            wb(1'b0, DATA_LOW, 32'h0, q);
            chk("data read", 32'(ee_model[k]), q);
            wb(1'b0, DATA_LOW, 32'h0, q);
            chk("data held", 32'(ee_model[k]), q);
        end
        $display("test read done");
        // erase one random block, then read both of its end words
        a = 8'($random(seed));
        d = 8'($random(seed)) & 8'h03;
        wb(1'b1, ADDR_LOW, {24'h0, a}, q);
        wb(1'b1, ADDR_HIGH, {24'h0, d}, q);
        wb(1'b1, CONTROL, 32'h94, q);
        unlock_go(8'h96);
        wait_done();
        chk("stall length", 32'(ELEN), 32'(stall_cnt));
        wb(1'b0, STATUS, 32'h0, q);
        chk("erase flag", 32'h1, q);
        for (int k = 0; k < 32; k += 31) begin
            wb(1'b1, ADDR_LOW, {24'h0, a[7:5], 5'(k)}, q);
            wb(1'b1, CONTROL, 32'h81, q);
            wb(1'b0, DATA_LOW, 32'h0, q);
            chk("flash low", 32'hFF, q);
            wb(1'b0, DATA_HIGH, 32'h0, q);
            chk("flash high", 32'h3F, q);
        end
        chk("skip count", 32'h2, 32'(skip_cnt));
        $display("test erase done");
        close_out();
    end
endmodule
`default_nettype wire
